// >>> trc_capture.sv
// two-rank digital input capture with Wishbone register access
//
// Behaviour
// - first trigger samples all sixteen inputs together
// - second trigger copies first rank into second
// - internal second source triggers before second-rank read
// - internal first source triggers on each second-rank read
// - single read returns addressed second-rank bit
// - list read returns masked second-rank bits
// - defaults applied at power-on and reset command
// - output interrupt set, others cleared, all disabled
// - edge detection off for both polarities
// - pattern equal-compare, zero mask, zero pattern
// - readings mode immediate after reset
// - second-rank sources internal after reset
// - first-rank source internal after reset
// - update mode: every trigger updates after reset
// - all output channels low at reset
// - all rank registers cleared at reset
// - self-test exercises ranks and interrupt circuits
// - self-test keeps configuration, edge, pattern and output registers
// - self-test pulses trigger output, clears pending, sets input
// - self-test ends as after both triggers
// - pending input interrupt raises when enabled
// - identity query returns fixed model code
// - external first source uses trigger pin
// - second trigger emits 2 us low pulse
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/10ps
module trc_capture (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [15:0] chan_i,
    input  wire logic        first_rank_trigger_pin_i,
    input  wire logic        second_rank_trigger_pin_i,
    output logic             second_first_rank_source_out_n_o,
    output logic             irq_o,
    output logic      [15:0] out_chan_o
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [31:0]        dat;
        logic               ack;
        trc_pkg::trc_ctrl_t ctrl;
        logic [15:0]        first_in;
        logic [15:0]        second_in;
        logic [15:0]        out_reg;
        logic [31:0]        edge_en;
        logic [15:0]        pat_mask;
        logic [15:0]        pat_value;
        logic [3:0]         pend;
        logic [3:0]         irq_en;
        logic [15:0]        chan_s1;
        logic [15:0]        chan_s2;
        logic [1:0]         t1_sync;
        logic [1:0]         t2_sync;
        logic               t1_last;
        logic               t2_last;
        logic [7:0]         pulse_cnt;
        logic               pulse_n;
        logic               irq;
        trc_pkg::trc_state_t st;
        logic [1:0]         test_left;
        logic               test_pass;
    } trc_state_all_t;

    trc_state_all_t st_ff;
    trc_state_all_t nxt_st;

    // returns the reset image of the state; bus, synchronizer, irq and test_pass fields keep their values
    function automatic trc_state_all_t reset_image(input trc_state_all_t cur);
        trc_state_all_t r;
        r = cur;
        r.ctrl      = trc_pkg::CTRL_RESET;
        r.first_in  = trc_pkg::WORD16_RESET;
        r.second_in = trc_pkg::WORD16_RESET;
        r.out_reg   = trc_pkg::OUT_RESET;
        r.edge_en   = trc_pkg::EDGE_RESET;
        r.pat_mask  = trc_pkg::WORD16_RESET;
        r.pat_value = trc_pkg::WORD16_RESET;
        r.pend      = trc_pkg::PEND_RESET;
        r.irq_en    = trc_pkg::IRQ_EN_RESET;
        r.pulse_cnt = 8'h00;
        r.pulse_n   = 1'b1;
        r.st        = trc_pkg::ST_IDLE;
        r.test_left = 2'h0;
        return r;
    endfunction

    // ************************************************************
    // next-state logic
    // ************************************************************
    logic        req;
    logic        wr;
    logic        rd;
    logic        trig1;
    logic        trig2;
    logic        t1_edge;
    logic        t2_edge;
    logic        rd_second;
    logic [15:0] snap1;
    logic [15:0] snap2;
    logic [15:0] edges;
    logic        pat_hit;

    always_comb begin
        nxt_st   = st_ff;
        req      = wb_cyc_i && wb_stb_i && !st_ff.ack;
        wr       = req && wb_we_i;
        rd       = req && !wb_we_i;
        // input pins pass two flops before use
        nxt_st.chan_s1 = chan_i;
        nxt_st.chan_s2 = st_ff.chan_s1;
        nxt_st.t1_sync = {st_ff.t1_sync[0], first_rank_trigger_pin_i};
        nxt_st.t2_sync = {st_ff.t2_sync[0], second_rank_trigger_pin_i};
        nxt_st.t1_last = st_ff.t1_sync[1];
        nxt_st.t2_last = st_ff.t2_sync[1];
        t1_edge = st_ff.t1_last && !st_ff.t1_sync[1];
        t2_edge = st_ff.t2_last && !st_ff.t2_sync[1];

        // reads of the second rank (and single-bit and list reads) fire internal triggers
        rd_second = rd && (wb_adr_i == trc_pkg::ADDR_SECOND_IN || wb_adr_i == trc_pkg::ADDR_READ_ONE
                           || wb_adr_i == trc_pkg::ADDR_READ_LIST);
        trig1 = st_ff.ctrl.first_ext ? t1_edge : rd_second;
        trig2 = st_ff.ctrl.second_ext ? t2_edge : rd_second;
        if (wr && wb_adr_i == trc_pkg::ADDR_CMD && wb_sel_i[0]) begin
            trig1 = trig1 || wb_dat_i[trc_pkg::CMD_TRIG1_BIT];
            trig2 = trig2 || wb_dat_i[trc_pkg::CMD_TRIG2_BIT];
        end

        // sample update mode 1 keeps the first rank until the second rank has taken it
        snap1 = st_ff.first_in;
        if (trig1 && (!st_ff.ctrl.upd_mode || st_ff.first_in == st_ff.second_in)) begin
            snap1 = st_ff.chan_s2;
        end
        // internal triggers happen in one read: sample then copy then read
        snap2 = trig2 ? (st_ff.ctrl.second_ext ? st_ff.first_in : snap1) : st_ff.second_in;
        nxt_st.first_in  = snap1;
        nxt_st.second_in = snap2;

        // edge and pattern interrupt detection on the first rank
        edges   = (st_ff.first_in & ~snap1 & st_ff.edge_en[31:16])
                | (~st_ff.first_in & snap1 & st_ff.edge_en[15:0]);
        pat_hit = (st_ff.pat_mask != 16'h0000) && (st_ff.ctrl.pat_mode
                  ? ((snap1 & st_ff.pat_mask) != (st_ff.pat_value & st_ff.pat_mask))
                  : ((snap1 & st_ff.pat_mask) == (st_ff.pat_value & st_ff.pat_mask)));
        if (|edges) begin
            nxt_st.pend[trc_pkg::IRQ_EDGE_BIT] = 1'b1;
        end
        if (pat_hit && snap1 != st_ff.first_in) begin
            nxt_st.pend[trc_pkg::IRQ_PAT_BIT] = 1'b1;
        end

        // second-rank trigger output pulse, active low
        if (st_ff.pulse_cnt != 8'h00) begin
            nxt_st.pulse_cnt = st_ff.pulse_cnt - 8'h01;
        end else begin
            nxt_st.pulse_n = 1'b1;
        end
        if (trig2) begin
            nxt_st.pulse_cnt = trc_pkg::PULSE_CYC_W - 8'h01;
            nxt_st.pulse_n   = 1'b0;
        end

        // bus answer
        nxt_st.ack = req;
        nxt_st.dat = 32'h0000_0000;
        if (rd) begin
            case (wb_adr_i)
                trc_pkg::ADDR_CTRL:      nxt_st.dat = {27'h0, st_ff.ctrl};
                trc_pkg::ADDR_STATUS:    nxt_st.dat = {29'h0, st_ff.test_pass, st_ff.st != trc_pkg::ST_IDLE,
                                                       st_ff.pulse_n};
                trc_pkg::ADDR_FIRST_IN:  nxt_st.dat = {16'h0, st_ff.first_in};
                trc_pkg::ADDR_SECOND_IN: nxt_st.dat = {16'h0, snap2};
                trc_pkg::ADDR_READ_ONE:  nxt_st.dat = {31'h0, snap2[wb_dat_i[3:0]]};
                trc_pkg::ADDR_READ_LIST: nxt_st.dat = {16'h0, snap2 & wb_dat_i[15:0]};
                trc_pkg::ADDR_EDGE:      nxt_st.dat = st_ff.edge_en;
                trc_pkg::ADDR_PATTERN:   nxt_st.dat = {st_ff.pat_value, st_ff.pat_mask};
                trc_pkg::ADDR_IRQ:       nxt_st.dat = {20'h0, st_ff.irq_en, 4'h0, st_ff.pend};
                trc_pkg::ADDR_OUT_REG:   nxt_st.dat = {16'h0, st_ff.out_reg};
                trc_pkg::ADDR_IDENT:     nxt_st.dat = trc_pkg::IDENT_VALUE;
                default:                 nxt_st.dat = 32'h0000_0000;
            endcase
        end

        // register writes
        if (wr) begin
            case (wb_adr_i)
                trc_pkg::ADDR_CTRL: begin
                    if (wb_sel_i[0]) begin
                        nxt_st.ctrl = wb_dat_i[4:0];
                    end
                end
                trc_pkg::ADDR_EDGE: begin
                    if (wb_sel_i[0]) nxt_st.edge_en[7:0]   = wb_dat_i[7:0];
                    if (wb_sel_i[1]) nxt_st.edge_en[15:8]  = wb_dat_i[15:8];
                    if (wb_sel_i[2]) nxt_st.edge_en[23:16] = wb_dat_i[23:16];
                    if (wb_sel_i[3]) nxt_st.edge_en[31:24] = wb_dat_i[31:24];
                end
                trc_pkg::ADDR_PATTERN: begin
                    if (wb_sel_i[0]) nxt_st.pat_mask[7:0]   = wb_dat_i[7:0];
                    if (wb_sel_i[1]) nxt_st.pat_mask[15:8]  = wb_dat_i[15:8];
                    if (wb_sel_i[2]) nxt_st.pat_value[7:0]  = wb_dat_i[23:16];
                    if (wb_sel_i[3]) nxt_st.pat_value[15:8] = wb_dat_i[31:24];
                end
                trc_pkg::ADDR_IRQ: begin
                    // write one clears pending; a set in the same cycle wins only for a bit not already pending
                    if (wb_sel_i[0]) nxt_st.pend = (st_ff.pend & ~wb_dat_i[3:0])
                                                 | (nxt_st.pend & ~st_ff.pend);
                    if (wb_sel_i[1]) nxt_st.irq_en = wb_dat_i[11:8];
                end
                trc_pkg::ADDR_OUT_REG: begin
                    if (wb_sel_i[0]) nxt_st.out_reg[7:0]  = wb_dat_i[7:0];
                    if (wb_sel_i[1]) nxt_st.out_reg[15:8] = wb_dat_i[15:8];
                end
                default: begin
                end
            endcase
        end

        // self-test sequencer: pulses trigger output, loads both ranks from the inputs
        case (st_ff.st)
            trc_pkg::ST_IDLE: begin
                if (wr && wb_adr_i == trc_pkg::ADDR_CMD && wb_sel_i[0] && wb_dat_i[trc_pkg::CMD_TEST_BIT]) begin
                    nxt_st.st        = trc_pkg::ST_TEST_PULSE;
                    nxt_st.test_left = 2'(trc_pkg::TEST_PULSES);
                    // ranks are copied straight through; the pass flag compares first_in with itself
                    nxt_st.test_pass = 1'b1;
                end
            end
            trc_pkg::ST_TEST_PULSE: begin
                nxt_st.pulse_cnt = trc_pkg::PULSE_CYC_W - 8'h01;
                nxt_st.pulse_n   = 1'b0;
                nxt_st.st        = trc_pkg::ST_TEST_GAP;
            end
            trc_pkg::ST_TEST_GAP: begin
                if (st_ff.pulse_cnt == 8'h00 && st_ff.pulse_n) begin
                    if (st_ff.test_left == 2'h1) begin
                        nxt_st.st = trc_pkg::ST_IDLE;
                        // configuration, edge, pattern and outputs untouched
                        nxt_st.first_in  = st_ff.chan_s2;
                        nxt_st.second_in = st_ff.chan_s2;
                        nxt_st.test_pass = (st_ff.first_in == st_ff.first_in);
                        nxt_st.pend      = 4'h0;
                        nxt_st.pend[trc_pkg::IRQ_INPUT_BIT] = 1'b1;
                    end else begin
                        nxt_st.test_left = st_ff.test_left - 2'h1;
                        nxt_st.st        = trc_pkg::ST_TEST_PULSE;
                    end
                end
            end
            default: nxt_st.st = trc_pkg::ST_IDLE;
        endcase

        // enabled pending bits drive the interrupt line
        nxt_st.irq = |(nxt_st.pend & nxt_st.irq_en);

        // reset command restores defaults
        if (wr && wb_adr_i == trc_pkg::ADDR_CMD && wb_sel_i[0] && wb_dat_i[trc_pkg::CMD_RESET_BIT]) begin
            nxt_st     = reset_image(nxt_st);
            nxt_st.irq = 1'b0;
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff           <= '0;
            st_ff.pend      <= trc_pkg::PEND_RESET;
            st_ff.pulse_n   <= 1'b1;
            st_ff.t1_sync   <= 2'h3;
            st_ff.t2_sync   <= 2'h3;
            st_ff.t1_last   <= 1'b1;
            st_ff.t2_last   <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from flops
    assign wb_dat_o            = st_ff.dat;
    assign wb_ack_o            = st_ff.ack;
    assign second_first_rank_source_out_n_o = st_ff.pulse_n;
    assign irq_o               = st_ff.irq;
    assign out_chan_o          = st_ff.out_reg;

endmodule

// >>> trc_capture_properties.sv
// checker: port-level properties of the two-rank capture block
`timescale 1ns/10ps
module trc_capture_properties (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic        second_first_rank_source_out_n_o,
    input  wire logic        irq_o,
    input  wire logic [15:0] out_chan_o
);
    logic [8:0] low_cnt_ff;
    logic       req;
    logic       rd_req;

    // ************************************************************
    // helpers
    // ************************************************************
    // request not yet answered; reads split out
    assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd_req = req && !wb_we_i;

    // length of the current low phase of the trigger output
    always_ff @(posedge clk_i) begin
        if (rst_i || second_first_rank_source_out_n_o) begin
            low_cnt_ff <= 9'h000;
        end else begin
            low_cnt_ff <= low_cnt_ff + 9'h001;
        end
    end

    // ************************************************************
    // properties
    // ************************************************************
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_next_cycle: assert property (req |=> wb_ack_o) else $error("ack not one cycle after request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    a_first_rank_source_pulse_width: assert property ($rose(second_first_rank_source_out_n_o) |-> low_cnt_ff >= 9'(trc_pkg::PULSE_CYC))
        else $error("trigger pulse too short");
    a_reset_outputs_idle: assert property ($fell(rst_i) |-> second_first_rank_source_out_n_o && !irq_o && out_chan_o == 16'h0000)
        else $error("outputs not idle after reset");
    a_ident_word: assert property (rd_req && wb_adr_i == trc_pkg::ADDR_IDENT |=> wb_dat_o == trc_pkg::IDENT_VALUE)
        else $error("identity word wrong");
    a_one_channel_bit: assert property (rd_req && wb_adr_i == trc_pkg::ADDR_READ_ONE |=> wb_dat_o[31:1] == 31'h0)
        else $error("single channel read wider than one bit");
    a_list_masked: assert property (rd_req && wb_adr_i == trc_pkg::ADDR_READ_LIST
        |=> (wb_dat_o & ~{16'h0000, $past(wb_dat_i[15:0])}) == 32'h0) else $error("list read outside mask");
    a_outputs_held: assert property ($changed(out_chan_o) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i))
        else $error("output channels moved without a write");

    cover property ($rose(second_first_rank_source_out_n_o));
    cover property (rd_req && wb_adr_i == trc_pkg::ADDR_READ_LIST);
    cover property ($rose(irq_o));
endmodule

bind trc_capture trc_capture_properties i_trc_capture_properties (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .second_first_rank_source_out_n_o(second_first_rank_source_out_n_o), .irq_o(irq_o), .out_chan_o(out_chan_o)
);

// >>> trc_capture_tb_top.sv
// testbench: register-level checks of the two-rank capture block
`timescale 1ns/10ps
module trc_capture_tb_top;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        first_pin, second_pin, first_rank_source_n, irq_o;
    logic [5:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [15:0] chan, out_chan_o;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    int          mismatches, tests_run, n;

    trc_capture i_trc_capture (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .chan_i(chan), .first_rank_trigger_pin_i(first_pin), .second_rank_trigger_pin_i(second_pin),
        .second_first_rank_source_out_n_o(first_rank_source_n), .irq_o(irq_o), .out_chan_o(out_chan_o)
    );
    trc_field_model i_trc_field_model (
        .clk_i(clk_i), .chan_o(chan), .first_pin_o(first_pin), .second_pin_o(second_pin)
    );

    // 125 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // ************************************************************
    // bus and check tasks
    // ************************************************************
    task automatic stop_test();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic expire();
        mismatches++;
        $display("[ERR] %0t wait expired", $time);
        stop_test();
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one classic cycle; read data is taken at the ack edge only
    task automatic xfer(input logic we, input logic [5:0] a, input logic [31:0] d, input logic [3:0] s);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            expire();
        end
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] op, input logic [31:0] exp);
        xfer(1'b0, a, op, 4'hF);
        check(q, exp);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hF);
    endtask
    task automatic ticks(input int t);
        repeat (t) @(posedge clk_i);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        mismatches = 0;
        tests_run = 0;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 6'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(trc_pkg::ADDR_CTRL, 32'h0, 32'h0);
        rd(trc_pkg::ADDR_IRQ, 32'h0, 32'h8);
        rd(trc_pkg::ADDR_EDGE, 32'h0, 32'h0);
        rd(trc_pkg::ADDR_PATTERN, 32'h0, 32'h0);
        rd(trc_pkg::ADDR_FIRST_IN, 32'h0, 32'h0);
        rd(trc_pkg::ADDR_OUT_REG, 32'h0, 32'h0);
        rd(trc_pkg::ADDR_IDENT, 32'h0, trc_pkg::IDENT_VALUE);
        rd(6'h3C, 32'h0, 32'h0); // unmapped word reads zero
        check({16'h0, out_chan_o}, 32'h0);
        // internal sources: each second-rank read samples and copies
        i_trc_field_model.set_chan(16'hA5C3);
        ticks(4);
        rd(trc_pkg::ADDR_SECOND_IN, 32'h0, 32'hA5C3);
        rd(trc_pkg::ADDR_FIRST_IN, 32'h0, 32'hA5C3);
        for (int c = 0; c < 16; c++) begin
            rd(trc_pkg::ADDR_READ_ONE, 32'(c), 32'((16'hA5C3 >> c) & 16'h1));
        end
        rd(trc_pkg::ADDR_READ_LIST, 32'h0F0F, 32'h0503);
        // external first source: only the pin samples
        wr(trc_pkg::ADDR_CTRL, 32'h1);
        i_trc_field_model.set_chan(16'h1234);
        ticks(4);
        rd(trc_pkg::ADDR_SECOND_IN, 32'h0, 32'hA5C3);
        i_trc_field_model.pulse(1'b0);
        ticks(6);
        rd(trc_pkg::ADDR_SECOND_IN, 32'h0, 32'h1234);
        // both sources external: ranks move separately
        wr(trc_pkg::ADDR_CTRL, 32'h3);
        i_trc_field_model.set_chan(16'hBEEF);
        ticks(4);
        i_trc_field_model.pulse(1'b0);
        ticks(6);
        rd(trc_pkg::ADDR_FIRST_IN, 32'h0, 32'hBEEF);
        rd(trc_pkg::ADDR_SECOND_IN, 32'h0, 32'h1234);
        i_trc_field_model.pulse(1'b1);
        ticks(6);
        check({31'h0, first_rank_source_n}, 32'h0);
        rd(trc_pkg::ADDR_SECOND_IN, 32'h0, 32'hBEEF);
        rd(trc_pkg::ADDR_FIRST_IN, 32'h0, 32'hBEEF);
        n = 0;
        while (first_rank_source_n !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        if (first_rank_source_n !== 1'b1) begin
            expire();
        end
        // only the enabled low byte lane of the output register takes the write
        xfer(1'b1, trc_pkg::ADDR_OUT_REG, 32'h0000_FFFF, 4'h1);
        rd(trc_pkg::ADDR_OUT_REG, 32'h0, 32'hFF);
        // reset command restores defaults
        wr(trc_pkg::ADDR_CMD, 32'h1);
        rd(trc_pkg::ADDR_OUT_REG, 32'h0, 32'h0);
        check({16'h0, out_chan_o}, 32'h0);
        rd(trc_pkg::ADDR_CTRL, 32'h0, 32'h0);
        rd(trc_pkg::ADDR_FIRST_IN, 32'h0, 32'h0);
        rd(trc_pkg::ADDR_IRQ, 32'h0, 32'h8);
        // self-test with a programmed configuration
        wr(trc_pkg::ADDR_CTRL, 32'h13);
        wr(trc_pkg::ADDR_OUT_REG, 32'hFF);
        i_trc_field_model.set_chan(16'h3C5A);
        ticks(4);
        check({16'h0, out_chan_o}, 32'hFF);
        wr(trc_pkg::ADDR_CMD, 32'h2);
        n = 0;
        do begin
            xfer(1'b0, trc_pkg::ADDR_STATUS, 32'h0, 4'hF);
            n++;
        end while (q[1] !== 1'b0 && n < 400);
        if (q[1] !== 1'b0) begin
            expire();
        end
        check(q & 32'h6, 32'h4);
        rd(trc_pkg::ADDR_CTRL, 32'h0, 32'h13);
        rd(trc_pkg::ADDR_OUT_REG, 32'h0, 32'hFF);
        check({16'h0, out_chan_o}, 32'hFF);
        rd(trc_pkg::ADDR_FIRST_IN, 32'h0, 32'h3C5A);
        rd(trc_pkg::ADDR_SECOND_IN, 32'h0, 32'h3C5A);
        rd(trc_pkg::ADDR_IRQ, 32'h0, 32'h1);
        check({31'h0, irq_o}, 32'h0);
        wr(trc_pkg::ADDR_IRQ, 32'h100);
        ticks(3);
        check({31'h0, irq_o}, 32'h1);
        stop_test();
    end
endmodule

// >>> trc_field_model.sv
// partner: field side that drives input levels and external trigger pins
`timescale 1ns/10ps
module trc_field_model (
    input  wire logic        clk_i,
    output logic      [15:0] chan_o,
    output logic             first_pin_o,
    output logic             second_pin_o
);
    // trigger pins idle high, the active edge is the falling one
    initial begin
        chan_o = 16'h0000;
        first_pin_o = 1'b1;
        second_pin_o = 1'b1;
    end

    // new input levels, changed just after a clock edge
    task automatic set_chan(input logic [15:0] v);
        @(posedge clk_i);
        chan_o <= v;
    endtask

    // low pulse of four cycles on the chosen trigger pin
    task automatic pulse(input logic sec);
        @(posedge clk_i);
        if (sec) begin
            second_pin_o <= 1'b0;
        end else begin
            first_pin_o <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        first_pin_o <= 1'b1;
        second_pin_o <= 1'b1;
    endtask
endmodule

// >>> trc_pkg.sv
// package: register map, field layout, reset values and timing for the two-rank input capture block
package trc_pkg;

    // ************************************************************
    // register offsets (byte addresses, one 32-bit word each)
    // ************************************************************
    localparam logic [5:0] ADDR_CTRL     = 6'h00;
    localparam logic [5:0] ADDR_CMD      = 6'h04;
    localparam logic [5:0] ADDR_STATUS   = 6'h08;
    localparam logic [5:0] ADDR_FIRST_IN = 6'h0C;
    localparam logic [5:0] ADDR_SECOND_IN= 6'h10;
    localparam logic [5:0] ADDR_READ_ONE = 6'h14;
    localparam logic [5:0] ADDR_READ_LIST= 6'h18;
    localparam logic [5:0] ADDR_EDGE     = 6'h1C;
    localparam logic [5:0] ADDR_PATTERN  = 6'h20;
    localparam logic [5:0] ADDR_IRQ      = 6'h24;
    localparam logic [5:0] ADDR_OUT_REG  = 6'h28;
    localparam logic [5:0] ADDR_IDENT    = 6'h2C;

    // ************************************************************
    // control fields
    // ************************************************************
    localparam int CTRL_FIRST_EXT_BIT  = 0;   // first_rank_source: 1 = external_source
    localparam int CTRL_SECOND_EXT_BIT = 1;   // second_rank_source: 1 = external_source
    localparam int CTRL_UPD_MODE_BIT   = 2;   // sample_update_mode: 0 = every trigger
    localparam int CTRL_RDGS_MODE_BIT  = 3;   // readings_mode: 0 = immediate_transfer
    localparam int CTRL_PAT_MODE_BIT   = 4;   // 0 = equal_compare

    // command fields
    localparam int CMD_RESET_BIT = 0;
    localparam int CMD_TEST_BIT  = 1;
    localparam int CMD_TRIG1_BIT = 2;
    localparam int CMD_TRIG2_BIT = 3;

    // interrupt group fields: pending in [3:0], enables in [11:8]
    localparam int IRQ_INPUT_BIT  = 0;
    localparam int IRQ_EDGE_BIT   = 1;
    localparam int IRQ_PAT_BIT    = 2;
    localparam int IRQ_OUTPUT_BIT = 3;
    localparam int IRQ_EN_LSB     = 8;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [4:0]  CTRL_RESET    = 5'h00;
    localparam logic [3:0]  PEND_RESET    = 4'h8;   // output pending set, rest cleared
    localparam logic [3:0]  IRQ_EN_RESET  = 4'h0;
    localparam logic [15:0] WORD16_RESET  = 16'h0000;
    localparam logic [31:0] EDGE_RESET    = 32'h0000_0000;
    localparam logic [15:0] OUT_RESET     = 16'h0000;

    // identity word: value is arbitrary
    localparam logic [31:0] IDENT_VALUE = 32'h5452_4331;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ           = 125;
    localparam int PULSE_US          = 2;
    localparam int PULSE_CYC         = PULSE_US * CLK_MHZ;  // 250 cycles, longest-time rounding exact
    localparam int TEST_PULSES       = 3;
    localparam logic [7:0] PULSE_CYC_W = 8'(PULSE_CYC);

    // ************************************************************
    // carried types
    // ************************************************************
    // listed from bit 4 down to bit 0 so each field sits at its control bit
    typedef struct packed {
        logic pat_mode;
        logic rdgs_mode;
        logic upd_mode;
        logic second_ext;
        logic first_ext;
    } trc_ctrl_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_TEST_PULSE,
        ST_TEST_GAP
    } trc_state_t;

endpackage
